// *** ref_ladder_pkg.sv ***
// Purpose: Shared constants and types for the reference ladder control block
// Assumes: Registers reached over a plain address/strobe port, 8-bit data
// Notes:   Each offset, field position and reset value is named once here

package ref_ladder_pkg;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam int          ADDR_W           = 4;
  localparam int          DATA_W           = 8;
  localparam logic [3:0]  ADDR_LADDER_CTRL = 4'h0; // control register
  localparam logic [3:0]  ADDR_LADDER_STAT = 4'h1; // applied-state readback
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  READ_UNMAPPED    = 8'h00;

  // ------------------------------------------------------------------
  // Field positions in the control register
  // ------------------------------------------------------------------
  localparam int          BIT_POWER_EN     = 7;
  localparam int          BIT_PIN_OE       = 6;
  localparam int          BIT_RANGE_SEL    = 5;
  localparam int          BIT_SOURCE_SEL   = 4;
  localparam int          LEVEL_MSB        = 3;
  localparam int          LEVEL_LSB        = 0;
  localparam int          LEVEL_W          = 4;

  // Ladder scaling denominators per range
  localparam logic [5:0]  DIV_LOW_RANGE    = 6'h18; // 24: code x span / 24
  localparam logic [5:0]  DIV_HIGH_RANGE   = 6'h20; // 32: span/4 + code x span/32

  // Range and source encodings
  typedef enum logic {RANGE_HIGH = 1'b0, RANGE_LOW = 1'b1} range_t;
  typedef enum logic {SRC_SUPPLY = 1'b0, SRC_EXT_REF = 1'b1} source_t;

  // Bundle of static controls handed to the analog ladder
  typedef struct packed {
    logic               powerEnable;
    logic               pinOutputEnable;
    range_t             rangeSelect;
    source_t            sourceSelect;
    logic [LEVEL_W-1:0] levelCode;
  } ladder_ctrl_t;

endpackage : ref_ladder_pkg

// *** reference_ladder_control.sv ***
// Purpose: Register and pin control for a 16-tap reference voltage ladder
// Assumes: One 40 MHz clock, async active-low reset, synchronous inputs
// Notes:   Analog ladder lies outside; it consumes the static controls here
//
// Behaviour
// - Ladder powered while control bit 7 is one, down when zero.
// - Bit 6 drives reference onto shared pin, overriding that pin's direction.
// - Bit 5 one: code times span/24; zero: span/4 plus code times span/32.
// - Bit 4 one: span is external reference pair; zero: device supply.
// - Bits 3-0 hold unsigned level code 0 to 15, sixteen taps.
// - Reset clears enable, output-enable, range and code bits.
// - Wake from sleep leaves every control bit unchanged.
// - Ladder works whatever the comparator configuration is.

`timescale 1ns/100ps

module reference_ladder_control
  import ref_ladder_pkg::*;
(
  input  wire logic                             core_clk,       // 40 MHz system clock
  input  wire logic                             rst_n,          // Async reset, active low
  input  wire logic                             clkEn,          // Freezes all state when low
  input  wire logic [ref_ladder_pkg::ADDR_W-1:0] regAddr,       // Register address
  input  wire logic [ref_ladder_pkg::DATA_W-1:0] regWdata,      // Write data
  input  wire logic                             regWrite,       // Write strobe
  input  wire logic                             regRead,        // Read strobe
  input  wire logic                             portFDirection, // Pin direction, 1 = input
  input  wire logic                             portFLatch,     // Pin digital output level
  output logic      [ref_ladder_pkg::DATA_W-1:0] regRdata,      // Read data, cycle after strobe
  output ref_ladder_pkg::ladder_ctrl_t          ladderCtrl,     // Static ladder controls
  output logic                                  ladderPowerOn,  // Ladder bias enable
  output logic                                  refPinAnalogOn, // Switch ladder onto pin
  output logic                                  pinDigitalOut,  // Pin digital output level
  output logic                                  pinDigitalOe    // Pin digital driver enable
);
  import ref_ladder_pkg::*;

  // ------------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] ctrlReg;
  logic [DATA_W-1:0] next_ctrlReg;

  // Decode helper shared by read and write paths
  function automatic logic hitAddr(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] target);
    return a == target;
  endfunction : hitAddr

  // Unpack the raw byte into the ladder bundle
  function automatic ladder_ctrl_t unpackCtrl(input logic [DATA_W-1:0] r);
    ladder_ctrl_t c;
    c.powerEnable     = r[BIT_POWER_EN];
    c.pinOutputEnable = r[BIT_PIN_OE];
    c.rangeSelect     = range_t'(r[BIT_RANGE_SEL]);
    c.sourceSelect    = source_t'(r[BIT_SOURCE_SEL]);
    c.levelCode       = r[LEVEL_MSB:LEVEL_LSB];
    return c;
  endfunction : unpackCtrl

  // Next value: only a write changes it; sleep and wake have no path here
  always_comb begin
    next_ctrlReg = ctrlReg;
    if (regWrite && hitAddr(regAddr, ADDR_LADDER_CTRL)) begin
      next_ctrlReg = regWdata;
    end
  end

  // No comparator mode input exists, so nothing can gate the ladder
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= CTRL_RESET;
    end else if (clkEn) begin
      ctrlReg <= next_ctrlReg;
    end
  end

  // ------------------------------------------------------------------
  // Ladder and pin outputs
  // ------------------------------------------------------------------
  ladder_ctrl_t next_ladderCtrl;
  logic         next_ladderPowerOn;
  logic         next_refPinAnalogOn;
  logic         next_pinDigitalOut;
  logic         next_pinDigitalOe;

  // Outputs follow the written value and the pin latch and direction inputs; registered so the ladder sees no glitches
  always_comb begin
    next_ladderCtrl     = unpackCtrl(next_ctrlReg);
    next_ladderPowerOn  = next_ladderCtrl.powerEnable;
    next_refPinAnalogOn = next_ladderCtrl.pinOutputEnable;
    next_pinDigitalOut  = portFLatch;
    // Reference output wins over direction: digital driver held off
    next_pinDigitalOe   = !portFDirection && !next_ladderCtrl.pinOutputEnable;
  end

  // Range and source bits pass untouched; the ladder applies 24 or 32 scaling
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ladderCtrl     <= ladder_ctrl_t'(CTRL_RESET);
      ladderPowerOn  <= 1'b0;
      refPinAnalogOn <= 1'b0;
      pinDigitalOut  <= 1'b0;
      pinDigitalOe   <= 1'b0;
    end else if (clkEn) begin
      ladderCtrl     <= next_ladderCtrl;
      ladderPowerOn  <= next_ladderPowerOn;
      refPinAnalogOn <= next_refPinAnalogOn;
      pinDigitalOut  <= next_pinDigitalOut;
      pinDigitalOe   <= next_pinDigitalOe;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [DATA_W-1:0] next_regRdata;

  // Read data valid only in the cycle after the strobe, zero otherwise
  always_comb begin
    next_regRdata = READ_UNMAPPED;
    if (regRead) begin
      if (hitAddr(regAddr, ADDR_LADDER_CTRL)) begin
        next_regRdata = ctrlReg;
      end else if (hitAddr(regAddr, ADDR_LADDER_STAT)) begin
        next_regRdata = ladderCtrl; // applied state seen by the ladder
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= READ_UNMAPPED;
    end else if (clkEn) begin
      regRdata <= next_regRdata;
    end
  end

endmodule : reference_ladder_control

// *** ladder_model.sv ***
// Purpose: Behavioural ladder, tap level in 96ths of span
// Assumes: Static controls from the ladder control block
// Notes:   Span source is only a select; no voltage modelled
`timescale 1ns/100ps
module ladder_model
  import ref_ladder_pkg::*;
(
  input  wire ref_ladder_pkg::ladder_ctrl_t ctrl, // Static controls
  output logic [7:0]                        tap   // Level, 96ths of span
);
  // Unpowered ladder gives no level
  always_comb begin
    tap = 8'h00;
    if (ctrl.powerEnable && ctrl.rangeSelect == RANGE_LOW) tap = 8'(ctrl.levelCode) * 8'h04;
    else if (ctrl.powerEnable) tap = 8'h18 + 8'(ctrl.levelCode) * 8'h03;
  end
endmodule : ladder_model

// *** reference_ladder_control_asserts.sv ***
// Purpose: Port-level checks of the ladder control
// Assumes: Single clock domain
// Notes:   Bound onto every instance
`timescale 1ns/100ps
module reference_ladder_control_asserts
  import ref_ladder_pkg::*;
(
  input wire logic               core_clk,       // Clock
  input wire logic               rst_n,          // Reset
  input wire logic               clkEn,          // Enable
  input wire logic [ADDR_W-1:0]  regAddr,        // Address
  input wire logic [DATA_W-1:0]  regWdata,       // Write data
  input wire logic               regWrite,       // Write
  input wire logic               regRead,        // Read
  input wire logic               portFDirection, // Direction
  input wire logic [DATA_W-1:0]  regRdata,       // Read data
  input wire ladder_ctrl_t       ladderCtrl,     // Controls
  input wire logic               ladderPowerOn,  // Power
  input wire logic               refPinAnalogOn, // Analog pin
  input wire logic               pinDigitalOe    // Digital driver
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr; clkEn && regWrite && regAddr == ADDR_LADDER_CTRL; endsequence
  sequence s_rd; clkEn && regRead && regAddr == ADDR_LADDER_CTRL; endsequence
  property p_wr; s_wr |=> ladderCtrl == $past(regWdata); endproperty
  property p_hold;
    !(clkEn && regWrite && regAddr == ADDR_LADDER_CTRL) |=> $stable(ladderCtrl);
  endproperty
  property p_rd; s_rd |=> regRdata == $past(ladderCtrl); endproperty
  property p_rdz; clkEn && !regRead |=> regRdata == 8'h00; endproperty
  property p_pw; ladderPowerOn == ladderCtrl.powerEnable; endproperty
  property p_oe; refPinAnalogOn |-> refPinAnalogOn == ladderCtrl.pinOutputEnable && !pinDigitalOe;
  endproperty
  property p_dir; clkEn |=> pinDigitalOe == (!$past(portFDirection) && !ladderCtrl[6]); endproperty
  property p_rst; $rose(rst_n) |-> ladderCtrl == CTRL_RESET && !ladderPowerOn; endproperty
  a_wr: assert property (p_wr) else $error("control not loaded");
  a_hold: assert property (p_hold) else $error("control moved");
  a_rd: assert property (p_rd) else $error("bad readback");
  a_rdz: assert property (p_rdz) else $error("read data left up");
  a_pw: assert property (p_pw) else $error("power mismatch");
  a_oe: assert property (p_oe) else $error("pin conflict");
  a_dir: assert property (p_dir) else $error("direction not overridden");
  a_rst: assert property (p_rst) else $error("reset value");
endmodule : reference_ladder_control_asserts
bind reference_ladder_control reference_ladder_control_asserts chk (.*);

// *** testbench.sv ***
// Purpose: Random and corner traffic on the ladder control
// Assumes: 25 ns core_clk, reset held 10 cycles
// Notes:   No handshake waits; the slave never stalls
`timescale 1ns/100ps
module testbench;
  import ref_ladder_pkg::*;
  logic core_clk = 0, rst_n = 0, clkEn = 1, regWrite = 0, regRead = 0, dir = 1, lat = 0;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWdata = 8'h00, regRdata, tap, d;
  logic [7:0] corner [4] = '{8'hff, 8'h8f, 8'hb0, 8'h4f};
  ladder_ctrl_t ladderCtrl;
  logic pOn, aOn, dOut, dOe;
  int failures = 0, checks_done = 0;
  reference_ladder_control uut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .portFDirection(dir), .portFLatch(lat), .regRdata(regRdata), .ladderCtrl(ladderCtrl),
    .ladderPowerOn(pOn), .refPinAnalogOn(aOn), .pinDigitalOut(dOut), .pinDigitalOe(dOe));
  ladder_model lm (.ctrl(ladderCtrl), .tap(tap));
  initial forever #12.5 core_clk = ~core_clk;
  // Expected tap from the raw control byte
  function automatic logic [7:0] exp_tap(input logic [7:0] v);
    if (!v[7]) return 8'h00;
    return v[5] ? 8'(v[3:0]) * 8'h04 : 8'h18 + 8'(v[3:0]) * 8'h03;
  endfunction : exp_tap
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // One strobe cycle; results settle just after the next edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    {regWrite, regRead, regAddr, regWdata} <= {w, !w, a, v};
    @(posedge core_clk);
    {regWrite, regRead} <= 2'b00;
    #1;
  endtask : bus
  task automatic end_sim;
    if (failures == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  initial begin
    void'($urandom(32'h7ce382f5));
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    bus(1'b0, ADDR_LADDER_CTRL, 8'h00);
    chk("reset", CTRL_RESET, regRdata);
    for (int i = 0; i < 40; i++) begin
      d = (i < 4) ? corner[i] : 8'($urandom);
      @(posedge core_clk);
      {dir, lat} <= 2'($urandom);
      bus(1'b1, ADDR_LADDER_CTRL, d);
      chk("ctrl", d, ladderCtrl);
      chk("power", {7'h0, d[7]}, {7'h0, pOn});
      chk("pin", {5'h0, d[6], !dir && !d[6], lat}, {5'h0, aOn, dOe, dOut});
      chk("tap", exp_tap(d), tap);
      bus(1'b0, ADDR_LADDER_CTRL, 8'h00);
      chk("readback", d, regRdata);
    end
    bus(1'b1, 4'h5, ~d);
    chk("stray write", d, ladderCtrl);
    bus(1'b0, 4'h5, 8'h00);
    chk("unmapped", READ_UNMAPPED, regRdata);
    bus(1'b0, ADDR_LADDER_STAT, 8'h00);
    chk("status", d, regRdata);
    d = d & 8'h7f;
    bus(1'b1, ADDR_LADDER_CTRL, d);
    chk("sleep prep", 8'h00, {7'h0, pOn});
    clkEn <= 1'b0;
    bus(1'b1, ADDR_LADDER_CTRL, ~d);
    chk("frozen", d, ladderCtrl);
    clkEn <= 1'b1;
    rst_n <= 1'b0;
    #2;
    chk("mid reset", CTRL_RESET, ladderCtrl);
    @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    end_sim();
  end
endmodule : testbench
